// ===== pkg/pin_mux_pkg.sv
package pin_mux_pkg;

    // Number of pins handled by this block (port 4 bits 3 to 7)
    localparam int PIN_COUNT = 5;
    // Bit position of the lowest pin (pin 3) inside the 8-bit port control bytes
    localparam int PIN_BASE = 3;
    localparam int PIN_CAP0 = 0;   // Pin 3 within the group
    localparam int PIN_CAP1 = 1;   // Pin 4
    localparam int PIN_OUT2 = 2;   // Pin 5
    localparam int PIN_TRI  = 3;   // Pin 6
    localparam int PIN_CLK  = 4;   // Pin 7

    // Register widths and reset values
    localparam int PORT_W = 8;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [4:0] GROUP_RST = 5'h00;

    // Register indices on the plain register port
    localparam logic [1:0] IDX_DIR    = 2'h0;
    localparam logic [1:0] IDX_SEL    = 2'h1;
    localparam logic [1:0] IDX_AEN    = 2'h2;
    localparam logic [1:0] IDX_OPAMP  = 2'h3;

    // Op-amp routing field layout inside the op-amp register
    localparam int ROUTE_LSB = 0;
    localparam int FUNC_LSB  = 2;
    localparam logic [1:0] ROUTE_INTERNAL = 2'h3;
    localparam logic [2:0] FUNC_OFF       = 3'h0;
    localparam logic [4:0] OPAMP_RST      = 5'h00;

    // Functions a pin can be in
    typedef enum logic [1:0] {
        FN_GPIO,
        FN_PERIPH_IN,
        FN_PERIPH_OUT,
        FN_ANALOG
    } pin_fn_e;

endpackage

// ===== verilog/pin_cell.sv
`timescale 1ns/10ps
// One pad's digital output stage and input gate
module pin_cell
    import pin_mux_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic dir_i,        // Direction bit
    input  wire logic sel_i,        // Function-select bit
    input  wire logic aen_i,        // Analog-enable bit
    input  wire logic gpio_out_i,   // Port output data
    input  wire logic periph_out_i, // Peripheral output value
    input  wire logic pad_in_i,     // Pad level
    output logic      pad_out_o,    // Pad drive value
    output logic      pad_oe_o,     // Pad driver enable
    output logic      dig_in_o,     // Schmitt path level, 0 when gated
    output logic      periph_in_o   // Pad level toward the peripheral
);
    // Combined selection terms
    wire logic digital_w   = ~aen_i;
    wire logic drive_w     = digital_w & dir_i;
    wire logic out_val_w   = sel_i ? periph_out_i : gpio_out_i;
    wire logic in_gate_w   = digital_w & pad_in_i;
    wire logic periph_en_w = digital_w & sel_i & ~dir_i;

    // Driver and data come from flip-flops
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pad_out_o <= 1'b0;
            pad_oe_o  <= 1'b0;
        end else begin
            pad_out_o <= out_val_w;
            pad_oe_o  <= drive_w;   // Analog mode kills the driver
        end
    end

    // Schmitt input gated off in analog mode
    assign dig_in_o    = in_gate_w;
    assign periph_in_o = periph_en_w & pad_in_i;
endmodule

// ===== verilog/port4_upper_pin_function_mux.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// RULE1 - Both select bits low gives plain GPIO
// RULE2 - Reset leaves every pin as GPIO
// RULE3 - Pins 3,4 input feed alternate captures
// RULE4 - Pins 3,4 output carry compare 0,1
// RULE5 - Pin 5 output carries compare 2
// RULE6 - Pin 6 output function drives ground
// RULE7 - Analog enable connects converter or op-amp
// RULE8 - Analog enable disables driver and Schmitt input
// RULE9 - Internal routing ties channels 12,13 to op-amps
// RULE10 - Internal routing disconnects pads from analog
// RULE11 - Pin 6 input tristate, pin 7 clock
// RULE12 - Pin 7 output function drives ground
module port4_upper_pin_function_mux
    import pin_mux_pkg::*;
#(
    // Pins in the group, pin 3 upward
    parameter int NPINS = PIN_COUNT
)
(
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,

    // Plain register port
    input  wire logic [1:0]       reg_addr_i,
    input  wire logic [7:0]       reg_wdata_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    output logic      [7:0]       reg_rdata_o,

    // Pad side, bit 0 is pin 3
    input  wire logic [NPINS-1:0] port_out_data_i,
    input  wire logic [NPINS-1:0] pad_in_i,
    output logic      [NPINS-1:0] pad_out_o,
    output logic      [NPINS-1:0] pad_oe_o,
    output logic      [NPINS-1:0] port_in_o,
    output logic      [NPINS-1:0] analog_pad_connect_o,

    // Second timer side
    input  wire logic             second_timer_out0_i,
    input  wire logic             second_timer_out1_i,
    input  wire logic             second_timer_out2_i,
    output logic                  capture0_alternate_input_o,
    output logic                  capture1_alternate_input_o,
    output logic                  timer_output_tristate_in_o,
    output logic                  timer_external_clock_in_o,

    // Converter and op-amp side
    output logic                  converter_channel_twelve_from_opamp_o,
    output logic                  converter_channel_thirteen_from_opamp_o
);
    // Control registers, all cleared by power-up clear.
    // Only the group bits are stored; the other bits of each byte are
    // ignored on write and read back as zero, except bit 7 of index 3
    logic [NPINS-1:0] port_four_direction_bits_r;    // 1 drives the pad
    logic [NPINS-1:0] port_four_function_select_r;   // 1 hands the pin to the timer
    logic [NPINS-1:0] upper_analog_enable_bits_r;    // 1 closes the analog switch of pins 3 to 6; the pin 7 bit is unused
    logic [4:0]       opamp_setting_r;               // Routing and function fields
    logic [7:0]       rdata_r;                       // Read data register

    // Register map on the plain port:
    //   index 0 - direction bits, pins in bits 7:3
    //   index 1 - function-select bits, same placement
    //   index 2 - analog-enable bits, pin 7 bit kept but unused
    //   index 3 - op-amp routing in bits 1:0, function in bits 4:2
    //   bit 7 of index 3 reads back the decoded internal route
    // Write decode; strobes never come together, so each stands alone
    wire logic wr_dir_w   = reg_wr_i & (reg_addr_i == IDX_DIR);     // Direction write
    wire logic wr_sel_w   = reg_wr_i & (reg_addr_i == IDX_SEL);     // Select write
    wire logic wr_aen_w   = reg_wr_i & (reg_addr_i == IDX_AEN);     // Analog enable write
    wire logic wr_opamp_w = reg_wr_i & (reg_addr_i == IDX_OPAMP);   // Op-amp write

    // Op-amp fields
    wire logic [1:0] opamp_converter_routing = opamp_setting_r[ROUTE_LSB +: 2];
    wire logic [2:0] opamp_function_setting  = opamp_setting_r[FUNC_LSB +: 3];
    // Internal routing takes channels 12 and 13 off the pads, so an op-amp
    // output never fights a level that the board applies to pins 3 and 4
    wire logic internal_route_w = (opamp_converter_routing == ROUTE_INTERNAL)
                                & (opamp_function_setting != FUNC_OFF); // see RULE9

    // Direction bits; reset leaves every pin an input
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_four_direction_bits_r <= GROUP_RST;   // see RULE2
        end else if (wr_dir_w) begin
            port_four_direction_bits_r <= reg_wdata_i[PIN_BASE +: NPINS];
        end
    end

    // Function-select bits; reset returns every pin to GPIO
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_four_function_select_r <= GROUP_RST;   // see RULE2
        end else if (wr_sel_w) begin
            port_four_function_select_r <= reg_wdata_i[PIN_BASE +: NPINS];
        end
    end

    // Analog-enable bits; reset opens every analog switch
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            upper_analog_enable_bits_r <= GROUP_RST;   // see RULE2
        end else if (wr_aen_w) begin
            upper_analog_enable_bits_r <= reg_wdata_i[PIN_BASE +: NPINS];
        end
    end

    // Op-amp setting; reset turns internal routing off
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opamp_setting_r <= OPAMP_RST;
        end else if (wr_opamp_w) begin
            opamp_setting_r <= reg_wdata_i[4:0];
        end
    end

    // Read mux, placed in the upper bits as in the port byte;
    // bits outside the group read back as zero; index 3 holds the op-amp byte
    // The register below takes this value only in a read cycle
    logic [7:0] rd_mux_w;
    always_comb begin
        rd_mux_w = 8'h00;
        unique case (reg_addr_i)
            IDX_DIR:   rd_mux_w[PIN_BASE +: NPINS] = port_four_direction_bits_r;
            IDX_SEL:   rd_mux_w[PIN_BASE +: NPINS] = port_four_function_select_r;
            IDX_AEN:   rd_mux_w[PIN_BASE +: NPINS] = upper_analog_enable_bits_r;
            // Bit 7 shows the decoded internal route for software
            IDX_OPAMP: rd_mux_w = {internal_route_w, 2'h0, opamp_setting_r};
        endcase
    end

    // Read data stands only in the cycle after the strobe; clearing it
    // between reads keeps a stale value off the bus
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd_i ? rd_mux_w : 8'h00;
        end
    end
    assign reg_rdata_o = rdata_r;

    // Peripheral output value per pin; pins 6 and 7 drive ground.
    // The pad stage registers this value, so a compare edge reaches
    // the pad one clock after the timer raises it
    logic [NPINS-1:0] periph_out_w;   // Value chosen when select is 1
    assign periph_out_w[PIN_CAP0] = second_timer_out0_i;   // see RULE4
    assign periph_out_w[PIN_CAP1] = second_timer_out1_i;   // see RULE4
    assign periph_out_w[PIN_OUT2] = second_timer_out2_i;   // see RULE5
    assign periph_out_w[PIN_TRI]  = 1'b0;                  // see RULE6
    assign periph_out_w[PIN_CLK]  = 1'b0;                  // see RULE12

    // Pin 7 has no analog function: its enable bit reads back but
    // never closes a switch or gates the digital path
    logic [NPINS-1:0] aen_eff_w;   // Analog enable as the pads see it
    assign aen_eff_w = upper_analog_enable_bits_r & {1'b0, {(NPINS-1){1'b1}}};

    // Peripheral input levels per pin; pin 5 has no input function,
    // so its level goes nowhere
    logic [NPINS-1:0] periph_in_w;

    // One pad stage per pin; driver enable and drive value share one
    // edge, so a direction change never puts a stale value on the pad
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
            pin_cell u_cell (
                .clock_i      (clock_i),
                .rst_n_i      (rst_n_i),
                .dir_i        (port_four_direction_bits_r[gi]),   // see RULE1
                .sel_i        (port_four_function_select_r[gi]),
                .aen_i        (aen_eff_w[gi]),                    // see RULE8
                .gpio_out_i   (port_out_data_i[gi]),
                .periph_out_i (periph_out_w[gi]),
                .pad_in_i     (pad_in_i[gi]),
                .pad_out_o    (pad_out_o[gi]),
                .pad_oe_o     (pad_oe_o[gi]),
                .dig_in_o     (port_in_o[gi]),
                .periph_in_o  (periph_in_w[gi])
            );
        end
    endgenerate

    // Analog pad switch: on with analog enable, off when routed inside.
    // Pins 5 and 6 never take part in the internal routing, and pin 7
    // has no switch at all
    logic [NPINS-1:0] analog_w;   // Switch state before its register
    assign analog_w[PIN_CAP0] = aen_eff_w[PIN_CAP0] & ~internal_route_w;   // see RULE10
    assign analog_w[PIN_CAP1] = aen_eff_w[PIN_CAP1] & ~internal_route_w;   // see RULE10
    assign analog_w[PIN_OUT2] = aen_eff_w[PIN_OUT2];                       // see RULE7
    assign analog_w[PIN_TRI]  = aen_eff_w[PIN_TRI];                        // see RULE7
    assign analog_w[PIN_CLK]  = 1'b0;

    // Analog switch state, registered beside the pad drivers so that a
    // switch never closes while the digital driver is still on
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            analog_pad_connect_o <= GROUP_RST;
        end else begin
            analog_pad_connect_o <= analog_w;   // see RULE7
        end
    end

    // Internal route status for converter channels 12 and 13;
    // both follow one condition, so the pair never splits
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            converter_channel_twelve_from_opamp_o   <= 1'b0;
            converter_channel_thirteen_from_opamp_o <= 1'b0;
        end else begin
            converter_channel_twelve_from_opamp_o   <= internal_route_w;   // see RULE9
            converter_channel_thirteen_from_opamp_o <= internal_route_w;   // see RULE9
        end
    end

    // Peripheral inputs, gated to zero unless selected, so the timer
    // sees a quiet low while the pin serves any other function
    assign capture0_alternate_input_o = periph_in_w[PIN_CAP0];   // see RULE3
    assign capture1_alternate_input_o = periph_in_w[PIN_CAP1];   // see RULE3
    assign timer_output_tristate_in_o = periph_in_w[PIN_TRI];    // see RULE11
    assign timer_external_clock_in_o  = periph_in_w[PIN_CLK];    // see RULE11
endmodule

// ===== bench/pin_mux_assertions.sv
`timescale 1ns/10ps
// Port-level checks on the upper pin mux
module pin_mux_checker #(
    parameter int NPINS = 5
) (
    input wire logic             clock_i,
    input wire logic             rst_n_i,
    input wire logic             reg_rd_i,
    input wire logic [7:0]       reg_rdata_o,
    input wire logic [NPINS-1:0] pad_in_i,
    input wire logic [NPINS-1:0] pad_oe_o,
    input wire logic [NPINS-1:0] analog_pad_connect_o,
    input wire logic             capture0_alternate_input_o,
    input wire logic             capture1_alternate_input_o,
    input wire logic             timer_output_tristate_in_o,
    input wire logic             timer_external_clock_in_o,
    input wire logic             converter_channel_twelve_from_opamp_o,
    input wire logic             converter_channel_thirteen_from_opamp_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_analog_no_drive: assert property ((pad_oe_o & analog_pad_connect_o) == '0)
        else $error("driver on analog pin");
    a_read_data_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside read slot");
    a_capture0_pad: assert property (capture0_alternate_input_o |-> pad_in_i[0])
        else $error("capture 0 not pad level");
    a_capture1_pad: assert property (capture1_alternate_input_o |-> pad_in_i[1])
        else $error("capture 1 not pad level");
    a_tristate_pad: assert property (timer_output_tristate_in_o |-> pad_in_i[3])
        else $error("tristate input not pad level");
    a_ext_clock_pad: assert property (timer_external_clock_in_o |-> pad_in_i[4])
        else $error("clock input not pad level");
    a_route_pair: assert property (converter_channel_twelve_from_opamp_o
        == converter_channel_thirteen_from_opamp_o) else $error("routes differ");
    a_route_detach: assert property (converter_channel_twelve_from_opamp_o
        |-> analog_pad_connect_o[1:0] == 2'h0) else $error("pad still on analog");
    a_pin7_digital: assert property (!analog_pad_connect_o[4])
        else $error("pin 7 switched to analog");
    // Main scenarios reached
    cover property (converter_channel_twelve_from_opamp_o);
    cover property (capture0_alternate_input_o);
    cover property (|analog_pad_connect_o);
    cover property (timer_external_clock_in_o);
endmodule

bind port4_upper_pin_function_mux pin_mux_checker #(.NPINS(NPINS)) chk (.clock_i, .rst_n_i,
    .reg_rd_i, .reg_rdata_o, .pad_in_i, .pad_oe_o, .analog_pad_connect_o,
    .capture0_alternate_input_o, .capture1_alternate_input_o, .timer_output_tristate_in_o,
    .timer_external_clock_in_o, .converter_channel_twelve_from_opamp_o,
    .converter_channel_thirteen_from_opamp_o);

// ===== bench/board_model.sv
`timescale 1ns/10ps
// Board side of the pads: it drives a pin only while the chip does not
module board_model (
    input  wire logic [4:0] pad_oe_i,  // Chip driver enables
    input  wire logic [4:0] pad_out_i, // Chip drive values
    input  wire logic [4:0] board_i,   // Levels the board applies
    output logic      [4:0] pad_o      // Resolved pad levels
);
    assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & board_i);
endmodule

// ===== bench/port4_upper_pin_function_mux_tb.sv
`timescale 1ns/10ps
// Register-driven bench for the upper pin mux
module port4_upper_pin_function_mux_tb import pin_mux_pkg::*;;
    logic       clock_i = 1'b0; // Bench clock
    logic       rst_n_i = 1'b0; // Reset, active low
    logic [1:0] addr = 2'h0;    // Register index
    logic [7:0] wdata = 8'h00;  // Write data
    logic       wr = 1'b0;      // Write strobe
    logic       rd = 1'b0;      // Read strobe
    logic [4:0] pod = 5'h1a;    // Port output data
    logic [4:0] board = 5'h0b;  // Board levels
    logic [2:0] tmr = 3'h5;     // Compare outputs 0..2
    logic [7:0] rdata;          // Read data
    logic [4:0] pad, oe, pout, pin, conn;
    logic       c0, c1, tri_in, tclk, ch12, ch13;
    logic [7:0] op [4] = '{8'h07, 8'h03, 8'h06, 8'h1f}; // Op-amp settings
    logic       hit;            // Internal route expected
    int         bad_count = 0;
    int         checked = 0;

    always #50 clock_i = ~clock_i;

    port4_upper_pin_function_mux dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .port_out_data_i(pod), .pad_in_i(pad), .pad_out_o(pout),
        .pad_oe_o(oe), .port_in_o(pin), .analog_pad_connect_o(conn),
        .second_timer_out0_i(tmr[0]), .second_timer_out1_i(tmr[1]),
        .second_timer_out2_i(tmr[2]), .capture0_alternate_input_o(c0),
        .capture1_alternate_input_o(c1), .timer_output_tristate_in_o(tri_in),
        .timer_external_clock_in_o(tclk), .converter_channel_twelve_from_opamp_o(ch12),
        .converter_channel_thirteen_from_opamp_o(ch13));
    board_model bm (.pad_oe_i(oe), .pad_out_i(pout), .board_i(board), .pad_o(pad));

    // Compare one value and count it
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle register write
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask
    // One-cycle read, data checked in the following cycle
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1 cmp(rdata, e);
    endtask
    // Let registered pad outputs follow a control change
    task automatic settle;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    // Verdict and end of run
    task automatic stop_test;
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) rd_reg(2'(i), 8'h00);
        cmp(8'(pin), 8'h0b);
        cmp(8'(oe), 8'h00);
        // Plain outputs, then timer compare outputs and ground drive
        wr_reg(IDX_DIR, 8'hf8);
        settle;
        cmp(8'(pout), 8'h1a);
        cmp(8'(oe), 8'h1f);
        wr_reg(IDX_SEL, 8'hf8);
        settle;
        cmp(8'(pout), 8'h05);
        cmp(8'(oe), 8'h1f);
        @(posedge clock_i) tmr <= 3'h2;
        settle;
        cmp(8'(pout), 8'h02);
        // Peripheral inputs from two pad patterns
        @(posedge clock_i) board <= 5'h19;
        wr_reg(IDX_DIR, 8'h00);
        settle;
        cmp(8'(oe), 8'h00);
        cmp(8'({c0, c1, tri_in, tclk}), 8'h0b);
        @(posedge clock_i) board <= 5'h06;
        settle;
        cmp(8'({c0, c1, tri_in, tclk}), 8'h04);
        // Analog enable overrides drive and input path
        @(posedge clock_i) board <= 5'h0f;
        wr_reg(IDX_DIR, 8'hf8);
        wr_reg(IDX_AEN, 8'hf8);
        settle;
        cmp(8'(oe), 8'h10);
        cmp(8'(pin), 8'h00);
        cmp(8'(conn), 8'h0f);
        rd_reg(IDX_AEN, 8'hf8);
        // Op-amp routing table
        foreach (op[i]) begin
            hit = op[i][1:0] == 2'h3 && op[i][4:2] != 3'h0;
            wr_reg(IDX_OPAMP, op[i]);
            settle;
            cmp(8'({ch12, ch13}), hit ? 8'h03 : 8'h00);
            cmp(8'(conn), hit ? 8'h0c : 8'h0f);
        end
        rd_reg(IDX_OPAMP, 8'h9f);
        // Reset in mid-run returns every pin to a plain input
        @(posedge clock_i) rst_n_i <= 1'b0;
        @(posedge clock_i) rst_n_i <= 1'b1;
        #1 cmp(8'(oe), 8'h00);
        cmp(8'(conn), 8'h00);
        cmp(8'({ch12, ch13}), 8'h00);
        cmp(8'(pin), 8'h0f);
        for (int i = 0; i < 4; i++) rd_reg(2'(i), 8'h00);
        stop_test;
    end
endmodule
